// ===== core/cood_pkg.sv
// constants for the communication object dictionary bank
// assumes a 100 MHz clock and an object request port keyed by index and subindex
package cood_pkg;

  // ----------------------------------------------------------------------
  // object indexes
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_DEVICE_PROFILE_TYPE   = 16'h1000;
  localparam logic [15:0] IDX_FAULT_FLAGS           = 16'h1001;
  localparam logic [15:0] IDX_FAULT_HISTORY         = 16'h1003;
  localparam logic [15:0] IDX_SYNC_MESSAGE_ID       = 16'h1005;
  localparam logic [15:0] IDX_DEVICE_NAME           = 16'h1008;
  localparam logic [15:0] IDX_HARDWARE_VERSION      = 16'h1009;
  localparam logic [15:0] IDX_SOFTWARE_VERSION      = 16'h100a;
  localparam logic [15:0] IDX_GUARDING_PERIOD       = 16'h100c;
  localparam logic [15:0] IDX_GUARDING_MISS_LIMIT   = 16'h100d;
  localparam logic [15:0] IDX_GUARDING_MESSAGE_ID   = 16'h100e;
  localparam logic [15:0] IDX_DRIVE_OUTPUT_MONITOR  = 16'h60fd;
  localparam logic [15:0] IDX_EXTRA_DRIVE_INPUT     = 16'h60fe;

  // ----------------------------------------------------------------------
  // subindexes, fields and sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SUB_SINGLE         = 8'h00;
  localparam logic [7:0]  SUB_HISTORY_COUNT  = 8'h00;
  localparam logic [7:0]  SUB_HISTORY_FIRST  = 8'h01;
  localparam logic [7:0]  HISTORY_DEPTH      = 8'hff;   // entries 1..ff
  localparam logic [7:0]  HISTORY_LAST_SLOT  = 8'hfe;   // slots 0..fe
  localparam int          GENERIC_ERROR_BIT  = 0;
  localparam int          SYNC_PRODUCER_BIT  = 30;
  localparam logic [7:0]  COUNT_ZERO         = 8'h00;

  // ----------------------------------------------------------------------
  // reset values of writable objects
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_SYNC_MESSAGE_ID     = 32'h0000_0080;
  localparam logic [15:0] RST_GUARDING_PERIOD     = 16'h0000;
  localparam logic [7:0]  RST_GUARDING_MISS_LIMIT = 8'h00;
  localparam logic [31:0] RST_GUARDING_MESSAGE_ID = 32'h0000_0700;
  localparam logic [31:0] RST_EXTRA_DRIVE_INPUT   = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // answer codes and logged fault codes
  // ----------------------------------------------------------------------
  localparam logic [31:0] ABORT_NONE       = 32'h0000_0000;
  localparam logic [31:0] ABORT_NO_OBJECT  = 32'h0602_0000;
  localparam logic [31:0] ABORT_READ_ONLY  = 32'h0601_0002;
  localparam logic [31:0] ABORT_NO_SUB     = 32'h0609_0011;
  localparam logic [31:0] ABORT_BAD_VALUE  = 32'h0609_0030;
  localparam logic [31:0] GUARD_FAULT_CODE = 32'h0000_8130;

  // ----------------------------------------------------------------------
  // timing: guarding period unit
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int GUARD_UNIT_NS  = 1000000;                     // 1 ms
  localparam int GUARD_UNIT_CYC = GUARD_UNIT_NS / CLK_PERIOD_NS;
  localparam int GUARD_CNT_W    = 24;                          // 16 bit period x 8 bit limit

endpackage : cood_pkg

// ===== core/cood_fault_history.sv
// rolling fault history: newest entry at subindex 1, count at subindex 0
// assumes one log request per cycle at most; reads are combinational
`timescale 1ns/10ps
`default_nettype none
module cood_fault_history (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               log_valid,
  input  wire logic [31:0]        log_code,
  input  wire logic               clear,
  input  wire logic [7:0]         rd_sub,
  output logic      [7:0]         count,
  output logic      [31:0]        rd_data
);
  import cood_pkg::*;

  logic [31:0] mem [0:254];        // circular store, slot head = newest
  logic [7:0]  head;
  logic [7:0]  next_head;
  logic [7:0]  next_count;
  logic [8:0]  rd_sum;
  logic [7:0]  rd_slot;

  // ----------------------------------------------------------------------
  // head and count; a new entry in the clearing cycle survives the clear
  // ----------------------------------------------------------------------
  always_comb begin
    next_head  = head;
    next_count = count;
    if (clear) begin
      next_count = COUNT_ZERO;
    end
    if (log_valid) begin
      // moving head back shifts every older entry up one subindex
      next_head = (head == 8'h00) ? HISTORY_LAST_SLOT : head - 8'h01;
      if (next_count != HISTORY_DEPTH) begin
        next_count = next_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head  <= 8'h00;
      count <= COUNT_ZERO;
    end else if (ce) begin
      head  <= next_head;
      count <= next_count;
    end
  end

  // memory write kept apart: no reset on the storage array
  always_ff @(posedge clk) begin
    if (ce && log_valid) begin
      mem[next_head] <= log_code;
    end
  end

  // ----------------------------------------------------------------------
  // read: subindex k sits k-1 slots past the head, modulo 255
  // ----------------------------------------------------------------------
  always_comb begin
    rd_sum  = {1'b0, head} + {1'b0, rd_sub} - 9'h001;
    rd_slot = (rd_sum >= {1'b0, HISTORY_DEPTH}) ? 8'(rd_sum - {1'b0, HISTORY_DEPTH})
                                                : rd_sum[7:0];
    rd_data = mem[rd_slot];
  end

endmodule : cood_fault_history
`default_nettype wire

// ===== core/cood_guard_timer.sv
// node-guarding watchdog: period in ms times miss limit, restarted by each request
// assumes guard_req is a one-cycle pulse from the link layer
`timescale 1ns/10ps
`default_nettype none
module cood_guard_timer #(
  parameter int UNIT_CYC = cood_pkg::GUARD_UNIT_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic [15:0]        period_ms,
  input  wire logic [7:0]         miss_limit,
  input  wire logic               guard_req,
  output logic                    guard_error,
  output logic                    timeout_pulse
);
  import cood_pkg::*;

  logic [31:0]            pre;
  logic [31:0]            next_pre;
  logic [GUARD_CNT_W-1:0] ms_cnt;
  logic [GUARD_CNT_W-1:0] next_ms_cnt;
  logic [GUARD_CNT_W-1:0] limit_ms;
  logic                   armed;
  logic                   next_armed;
  logic                   next_guard_error;
  logic                   next_timeout;

  // ----------------------------------------------------------------------
  // counting starts at the first request; zero period or limit disables it
  // ----------------------------------------------------------------------
  always_comb begin
    limit_ms         = GUARD_CNT_W'(period_ms) * GUARD_CNT_W'(miss_limit);
    next_pre         = pre;
    next_ms_cnt      = ms_cnt;
    next_armed       = armed;
    next_guard_error = guard_error;
    next_timeout     = 1'b0;
    if (guard_req) begin
      next_armed       = 1'b1;
      next_pre         = 32'h0000_0000;
      next_ms_cnt      = '0;
      next_guard_error = 1'b0;
    end else if (armed && !guard_error && limit_ms != '0) begin
      if (pre == 32'(UNIT_CYC - 1)) begin
        next_pre    = 32'h0000_0000;
        next_ms_cnt = ms_cnt + GUARD_CNT_W'(1);
      end else begin
        next_pre = pre + 32'h0000_0001;
      end
      if (next_ms_cnt >= limit_ms) begin
        next_guard_error = 1'b1;
        next_timeout     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre           <= 32'h0000_0000;
      ms_cnt        <= '0;
      armed         <= 1'b0;
      guard_error   <= 1'b0;
      timeout_pulse <= 1'b0;
    end else if (ce) begin
      pre           <= next_pre;
      ms_cnt        <= next_ms_cnt;
      armed         <= next_armed;
      guard_error   <= next_guard_error;
      timeout_pulse <= next_timeout;
    end
  end

endmodule : cood_guard_timer
`default_nettype wire

// ===== core/cood_object_dictionary.sv
// communication object dictionary bank of a fieldbus option card
// assumes an object request port (index, subindex) driven by the protocol engine
//
// Function
// - device type: profile half, option half, read-only
// - error register bit 0 set on any error
// - every emergency error is logged in history
// - history subindex 0 holds 8-bit entry count
// - entries 1..ff rolling, newest at subindex 1
// - writing zero to count clears the history
// - sync identifier read/write, selects consume or produce
// - guard time 16-bit read/write in 1 ms
// - life time factor sets tolerated missed guard periods
// - guarding identifier 32-bit read/write
// - software version reports nonvolatile memory version
// - drive_output_monitor_object reports drive output states to network
// - extra_drive_input_object drives extra drive inputs from network
// - objects addressed by 16-bit index, comms 1000-1fff
`timescale 1ns/10ps
`default_nettype none
module cood_object_dictionary #(
  parameter logic [15:0] DEVICE_PROFILE   = 16'h0000,   // arbitrary value
  parameter logic [15:0] DEVICE_OPTIONS   = 16'h0000,   // arbitrary value
  parameter logic [31:0] DEVICE_NAME_STR  = 32'h4f44_4344,  // arbitrary value
  parameter logic [31:0] HW_VERSION_STR   = 32'h3031_3030,  // arbitrary value
  parameter int          GUARD_UNIT_COUNT = cood_pkg::GUARD_UNIT_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               req_valid,
  input  wire logic               req_write,
  input  wire logic [15:0]        req_index,
  input  wire logic [7:0]         req_subindex,
  input  wire logic [31:0]        req_wdata,
  output logic                    rsp_valid,
  output logic                    rsp_error,
  output logic      [31:0]        rsp_data,
  input  wire logic               emcy_valid,
  input  wire logic [31:0]        emcy_code,
  input  wire logic               error_present,
  input  wire logic [7:1]         error_class,
  input  wire logic               guard_req,
  input  wire logic [31:0]        nv_config_version,
  input  wire logic [31:0]        drive_output_states,
  output logic      [31:0]        extra_drive_inputs,
  output logic      [31:0]        sync_message_identifier,
  output logic                    sync_producer,
  output logic      [15:0]        guarding_period,
  output logic      [7:0]         guarding_miss_limit,
  output logic      [31:0]        guarding_message_identifier,
  output logic                    guarding_error,
  output logic      [7:0]         fault_flags
);
  import cood_pkg::*;

  // ----------------------------------------------------------------------
  // local signals
  // ----------------------------------------------------------------------
  logic [7:0]  hist_count;
  logic [31:0] hist_data;
  logic        hist_clear;
  logic        hist_log;
  logic [31:0] hist_code;
  logic        guard_timeout;
  logic        guard_pending;
  logic        next_guard_pending;
  logic [31:0] next_sync_id;
  logic [15:0] next_guard_period;
  logic [7:0]  next_miss_limit;
  logic [31:0] next_guard_id;
  logic [31:0] next_extra_inputs;
  logic        next_rsp_valid;
  logic        next_rsp_error;
  logic [31:0] next_rsp_data;
  logic [7:0]  next_fault_flags;
  logic        single_sub;
  logic        wr;
  logic        rd;

  // ----------------------------------------------------------------------
  // history and guarding helpers
  // ----------------------------------------------------------------------
  cood_fault_history u_history (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .log_valid (hist_log),
    .log_code  (hist_code),
    .clear   (hist_clear),
    .rd_sub  (req_subindex),
    .count   (hist_count),
    .rd_data (hist_data)
  );

  cood_guard_timer #(
    .UNIT_CYC (GUARD_UNIT_COUNT)
  ) u_guard (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .period_ms     (guarding_period),
    .miss_limit    (guarding_miss_limit),
    .guard_req     (guard_req),
    .guard_error   (guarding_error),
    .timeout_pulse (guard_timeout)
  );

  assign sync_producer = sync_message_identifier[SYNC_PRODUCER_BIT];

  // ----------------------------------------------------------------------
  // fault logging; an emergency takes the slot, a guard timeout waits a cycle
  // ----------------------------------------------------------------------
  always_comb begin
    hist_log           = emcy_valid || guard_pending;
    hist_code          = emcy_valid ? emcy_code : GUARD_FAULT_CODE;
    next_guard_pending = guard_pending;
    if (guard_timeout) begin
      next_guard_pending = 1'b1;
    end else if (!emcy_valid) begin
      next_guard_pending = 1'b0;
    end
    // generic bit follows the live condition, so it drops once all errors clear
    next_fault_flags = {error_class, 1'b0};
    next_fault_flags[GENERIC_ERROR_BIT] = error_present || guarding_error
                                          || (|error_class);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      guard_pending <= 1'b0;
      fault_flags   <= 8'h00;
    end else if (ce) begin
      guard_pending <= next_guard_pending;
      fault_flags   <= next_fault_flags;
    end
  end

  // ----------------------------------------------------------------------
  // object access decode: answer one cycle after the request is taken
  // ----------------------------------------------------------------------
  always_comb begin
    wr                = req_valid && req_write;
    rd                = req_valid && !req_write;
    single_sub        = (req_subindex == SUB_SINGLE);
    next_sync_id      = sync_message_identifier;
    next_guard_period = guarding_period;
    next_miss_limit   = guarding_miss_limit;
    next_guard_id     = guarding_message_identifier;
    next_extra_inputs = extra_drive_inputs;
    hist_clear        = 1'b0;
    next_rsp_valid    = req_valid;
    next_rsp_error    = 1'b0;
    next_rsp_data     = 32'h0000_0000;
    // full 16-bit index compare keeps the comms range apart from profile ones
    case (req_index)
      IDX_DEVICE_PROFILE_TYPE: begin
        next_rsp_data = {DEVICE_OPTIONS, DEVICE_PROFILE};
        if (wr) begin
          next_rsp_data  = ABORT_READ_ONLY;
          next_rsp_error = 1'b1;
        end
      end
      IDX_FAULT_FLAGS: begin
        next_rsp_data = {24'h00_0000, fault_flags};
        if (wr) begin
          next_rsp_data  = ABORT_READ_ONLY;
          next_rsp_error = 1'b1;
        end
      end
      IDX_FAULT_HISTORY: begin
        if (req_subindex == SUB_HISTORY_COUNT) begin
          next_rsp_data = {24'h00_0000, hist_count};
          if (wr && req_wdata != 32'h0000_0000) begin
            next_rsp_data  = ABORT_BAD_VALUE;                      // only zero accepted
            next_rsp_error = 1'b1;
          end else if (wr) begin
            hist_clear    = 1'b1;
            next_rsp_data = 32'h0000_0000;
          end
        end else if (req_subindex > hist_count) begin
          next_rsp_data  = ABORT_NO_SUB;
          next_rsp_error = 1'b1;
        end else begin
          next_rsp_data  = wr ? ABORT_READ_ONLY : hist_data;
          next_rsp_error = wr;
        end
      end
      IDX_SYNC_MESSAGE_ID: begin
        next_rsp_data = sync_message_identifier;
        if (wr) begin
          next_sync_id = req_wdata;
        end
      end
      IDX_DEVICE_NAME: begin
        next_rsp_data  = wr ? ABORT_READ_ONLY : DEVICE_NAME_STR;
        next_rsp_error = wr;
      end
      IDX_HARDWARE_VERSION: begin
        next_rsp_data  = wr ? ABORT_READ_ONLY : HW_VERSION_STR;
        next_rsp_error = wr;
      end
      IDX_SOFTWARE_VERSION: begin
        next_rsp_data  = wr ? ABORT_READ_ONLY : nv_config_version;
        next_rsp_error = wr;
      end
      IDX_GUARDING_PERIOD: begin
        next_rsp_data = {16'h0000, guarding_period};
        if (wr) begin
          next_guard_period = req_wdata[15:0];
        end
      end
      IDX_GUARDING_MISS_LIMIT: begin
        next_rsp_data = {24'h00_0000, guarding_miss_limit};
        if (wr) begin
          next_miss_limit = req_wdata[7:0];
        end
      end
      IDX_GUARDING_MESSAGE_ID: begin
        next_rsp_data = guarding_message_identifier;
        if (wr) begin
          next_guard_id = req_wdata;
        end
      end
      IDX_DRIVE_OUTPUT_MONITOR: begin
        next_rsp_data  = wr ? ABORT_READ_ONLY : drive_output_states;
        next_rsp_error = wr;
      end
      IDX_EXTRA_DRIVE_INPUT: begin
        next_rsp_data = extra_drive_inputs;
        if (wr) begin
          next_extra_inputs = req_wdata;
        end
      end
      // error bit set beside each abort: stored data equal to a code still reads as data
      default: begin
        next_rsp_data  = ABORT_NO_OBJECT;
        next_rsp_error = 1'b1;
      end
    endcase
    // single-valued objects exist only at subindex 0; reject others untouched
    if (req_index != IDX_FAULT_HISTORY && !single_sub && req_valid) begin
      next_rsp_error    = 1'b1;
      next_rsp_data     = ABORT_NO_SUB;
      next_sync_id      = sync_message_identifier;
      next_guard_period = guarding_period;
      next_miss_limit   = guarding_miss_limit;
      next_guard_id     = guarding_message_identifier;
      next_extra_inputs = extra_drive_inputs;
    end
    if (!rd && !wr) begin
      next_rsp_error = 1'b0;
      next_rsp_data  = 32'h0000_0000;
      hist_clear     = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_message_identifier     <= RST_SYNC_MESSAGE_ID;
      guarding_period             <= RST_GUARDING_PERIOD;
      guarding_miss_limit         <= RST_GUARDING_MISS_LIMIT;
      guarding_message_identifier <= RST_GUARDING_MESSAGE_ID;
      extra_drive_inputs          <= RST_EXTRA_DRIVE_INPUT;
      rsp_valid                   <= 1'b0;
      rsp_error                   <= 1'b0;
      rsp_data                    <= 32'h0000_0000;
    end else if (ce) begin
      sync_message_identifier     <= next_sync_id;
      guarding_period             <= next_guard_period;
      guarding_miss_limit         <= next_miss_limit;
      guarding_message_identifier <= next_guard_id;
      extra_drive_inputs          <= next_extra_inputs;
      rsp_valid                   <= next_rsp_valid;
      rsp_error                   <= next_rsp_error;
      rsp_data                    <= next_rsp_data;
    end
  end

  // note: velocity objects rely on pole counts and rpm display set by the user

endmodule : cood_object_dictionary
`default_nettype wire

// ===== verification/cood_od_checker.sv
// checker for the dictionary bank: answer timing, write effects, fault flag
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module cood_od_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [15:0] req_index,
  input wire logic [7:0]  req_subindex,
  input wire logic [31:0] req_wdata,
  input wire logic        rsp_valid,
  input wire logic        error_present,
  input wire logic [7:1]  error_class,
  input wire logic        guard_req,
  input wire logic [31:0] extra_drive_inputs,
  input wire logic [31:0] sync_message_identifier,
  input wire logic        sync_producer,
  input wire logic        guarding_error,
  input wire logic [7:0]  fault_flags
);
  import cood_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // --------------
  // properties
  // --------------
  // accepted write to a single-valued object
  sequence s_wr(logic [15:0] idx);
    ce && req_valid && req_write && req_index == idx && req_subindex == SUB_SINGLE;
  endsequence
  // flags lag their causes by one edge; the edge leaving reset is skipped
  sequence s_run;
    ce && !rst ##1 1'b1;
  endsequence
  AST_RSP_NEXT: assert property (ce && req_valid ##1 ce |-> rsp_valid)
    else $error("late answer");
  AST_RSP_SPUR: assert property ($past(ce) && !$past(req_valid) |-> !rsp_valid)
    else $error("answer without request");
  AST_FLAG_GENERIC: assert property (s_run |->
    fault_flags[GENERIC_ERROR_BIT] == $past(error_present | guarding_error | (|error_class)))
    else $error("generic flag wrong");
  AST_FLAG_CLASS: assert property (s_run |-> fault_flags[7:1] == $past(error_class))
    else $error("class flags wrong");
  AST_PRODUCER: assert property (sync_producer == sync_message_identifier[SYNC_PRODUCER_BIT])
    else $error("producer bit wrong");
  AST_SYNC_WR: assert property (s_wr(IDX_SYNC_MESSAGE_ID) |=>
    sync_message_identifier == $past(req_wdata)) else $error("sync id not written");
  AST_EXTRA_WR: assert property (s_wr(IDX_EXTRA_DRIVE_INPUT) |=>
    extra_drive_inputs == $past(req_wdata)) else $error("extra inputs not written");
  AST_GUARD_CLR: assert property (ce && guard_req |=> !guarding_error)
    else $error("guard error kept");
endmodule : cood_od_checker

bind cood_object_dictionary cood_od_checker u_cood_od_checker (
  .clk, .rst, .ce, .req_valid, .req_write, .req_index, .req_subindex, .req_wdata,
  .rsp_valid, .error_present, .error_class, .guard_req, .extra_drive_inputs,
  .sync_message_identifier, .sync_producer, .guarding_error, .fault_flags);
`default_nettype wire

// ===== verification/cood_master_model.sv
// network master model: one object access at a time
// assumes the bank answers on the edge that takes the request
`timescale 1ns/10ps
`default_nettype none
module cood_master_model (
  input  wire logic        clk,
  output logic             req_valid,
  output logic             req_write,
  output logic [15:0]      req_index,
  output logic [7:0]       req_subindex,
  output logic [31:0]      req_wdata,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic [31:0] rsp_data
);
  initial {req_valid, req_write, req_index, req_subindex, req_wdata} = '0;
  // released fields carry the inverse so stale values are never mistaken for live ones
  // pole counts and rpm display are taken as set; no velocity object is used
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] d, output logic e, output logic [31:0] q);
    @(posedge clk);
    req_valid    <= 1'b1;
    req_write    <= w;
    req_index    <= i;
    req_subindex <= s;
    req_wdata    <= d;
    @(posedge clk);
    req_valid    <= 1'b0;
    req_index    <= ~i;
    req_subindex <= ~s;
    req_wdata    <= ~d;
    #1;
    e = (rsp_valid === 1'b1) ? rsp_error : 1'bx;
    q = rsp_data;
  endtask : xfer
endmodule : cood_master_model
`default_nettype wire

// ===== verification/test_cood_object_dictionary.sv
// bench: master accesses and event pulses against expected object values
// assumes package, bank, checker and master model are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_cood_object_dictionary;
  import cood_pkg::*;
  localparam logic RD = 1'b0, WR = 1'b1, OK = 1'b0, AB = 1'b1;
  logic        clk, rst, ce, emcy_valid, error_present, guard_req, req_valid, req_write;
  logic        rsp_valid, rsp_error, sync_producer, guarding_error;
  logic [7:1]  error_class;
  logic [7:0]  req_subindex, fault_flags;
  logic [15:0] req_index;
  logic [31:0] req_wdata, rsp_data, emcy_code, extra_drive_inputs, sync_message_identifier;
  int          num_errors, cmp_count, cyc;
  cood_object_dictionary #(.DEVICE_PROFILE(16'h0192), .DEVICE_OPTIONS(16'h0003),
    .GUARD_UNIT_COUNT(4)) u_cood_object_dictionary (.clk, .rst, .ce,
    .req_valid, .req_write, .req_index, .req_subindex, .req_wdata, .rsp_valid,
    .rsp_error, .rsp_data, .emcy_valid, .emcy_code, .error_present, .error_class,
    .guard_req, .nv_config_version(32'h0000_0102), .drive_output_states(32'h0000_00a5),
    .extra_drive_inputs, .sync_message_identifier, .sync_producer, .guarding_period(),
    .guarding_miss_limit(), .guarding_message_identifier(), .guarding_error, .fault_flags);
  cood_master_model u_cood_master_model (.clk, .req_valid, .req_write, .req_index,
    .req_subindex, .req_wdata, .rsp_valid, .rsp_error, .rsp_data);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the roughly 135 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, input logic xe, input logic [31:0] xq);
    logic        e;
    logic [31:0] q;
    u_cood_master_model.xfer(w, i, s, d, e, q);
    chk($sformatf("abort %h.%h", i, s), {31'h0, xe}, {31'h0, e});
    chk($sformatf("data %h.%h", i, s), xq, q);
  endtask : acc
  task automatic ev(input logic g, input logic [31:0] c);
    @(posedge clk);
    guard_req  <= g;
    emcy_valid <= !g;
    emcy_code  <= c;
    @(posedge clk);
    guard_req  <= 1'b0;
    emcy_valid <= 1'b0;
  endtask : ev
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    {emcy_valid, error_present, guard_req, error_class, emcy_code} = '0;
    ce = 1'b1;
    {num_errors, cmp_count, cyc} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    acc(RD, 16'h1005, '0, '0, OK, 32'h80);
    acc(WR, 16'h100c, '0, 32'hffff_0005, OK, '0);
    acc(RD, 16'h100c, '0, '0, OK, 32'h5);
    acc(WR, 16'h100d, '0, 32'h302, OK, '0);
    acc(RD, 16'h100d, '0, '0, OK, 32'h2);
    acc(WR, 16'h100e, '0, 32'h705, OK, 32'h700);
    acc(RD, 16'h100e, '0, '0, OK, 32'h705);
    acc(WR, 16'h1005, '0, 32'h4000_0081, OK, 32'h80);
    chk("sync_producer", 32'h1, {31'h0, sync_producer});
    acc(WR, 16'h1000, '0, '1, AB, ABORT_READ_ONLY);
    acc(RD, 16'h1000, '0, '0, OK, 32'h0003_0192);
    acc(WR, 16'h1001, '0, '1, AB, ABORT_READ_ONLY);
    acc(RD, 16'h2000, '0, '0, AB, ABORT_NO_OBJECT);
    acc(RD, 16'h1005, 8'h01, '0, AB, ABORT_NO_SUB);
    acc(RD, 16'h100a, '0, '0, OK, 32'h0102);
    acc(RD, 16'h60fd, '0, '0, OK, 32'ha5);
    acc(WR, 16'h60fe, '0, 32'h5a3c, OK, '0);
    chk("extra_drive_inputs", 32'h5a3c, extra_drive_inputs);
    // two logged faults, newest first, then a refused and a real clear
    ev(1'b0, 32'h2310);
    ev(1'b0, 32'h3220);
    acc(RD, 16'h1003, '0, '0, OK, 32'h2);
    acc(RD, 16'h1003, 8'h01, '0, OK, 32'h3220);
    acc(RD, 16'h1003, 8'h02, '0, OK, 32'h2310);
    acc(RD, 16'h1003, 8'h03, '0, AB, ABORT_NO_SUB);
    acc(WR, 16'h1003, '0, 32'h1, AB, ABORT_BAD_VALUE);
    acc(WR, 16'h1003, '0, '0, OK, '0);
    // a fault offered while the clock enable is low must not be logged
    @(posedge clk);
    ce <= 1'b0;
    ev(1'b0, 32'h5555);
    ce <= 1'b1;
    acc(RD, 16'h1003, '0, '0, OK, '0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      error_present <= (k == 0);
      error_class   <= (k == 1) ? 7'h05 : 7'h00;
      acc(RD, 16'h1001, '0, '0, OK, (k == 0) ? 32'h1 : (k == 1) ? 32'hb : '0);
    end
    // guard window is 5 ms x 2 misses x 4 cycles = 40 cycles
    ev(1'b1, '0);
    repeat (35) @(posedge clk);
    #1;
    chk("guarding_error early", '0, {31'h0, guarding_error});
    repeat (10) @(posedge clk);
    #1;
    chk("guarding_error late", 32'h1, {31'h0, guarding_error});
    acc(RD, 16'h1003, 8'h01, '0, OK, GUARD_FAULT_CODE);
    ev(1'b1, '0);
    #1;
    chk("guarding_error clear", '0, {31'h0, guarding_error});
    stop_test();
  end
endmodule : test_cood_object_dictionary
`default_nettype wire
